// ===== verilog/scs_top.sv
// Strap sampler: captures board straps after power-up reset and decodes them
//
// Functional notes
// - Sample environment, float, shared-BIOS and base straps at power-up, then hold them.
// - Pull-downs default straps to zero, enabled only during the power-up sampling window.
// - Environment: 00 ROM, env_select_1 alone debug, env_select_0 alone development, both programming.
// - Float strap high in ROM or debug environment floats every strap pin.
// - Shared-BIOS strap zero disables sharing, one enables shared BIOS mode.
// - Base-address straps choose the configuration register pair location.
// - No base strap gives 2E/2F; base bit 0 alone gives 4E/4F.
// - Environment straps left low select internal ROM environment, code 00.
// - Read-only status byte at FF12 returns captured strap values.
// - In idle, non-GPIO strap pins float or drive their strap value.
// - With address configuration on and float-all off, address strap pins drive strap value in reset.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
module scs_top #(
    parameter bit          IDLE_DRIVE = 1'b1,
    parameter logic [15:0] CORE_BASE  = 16'h0000
) (
    input  wire logic                      ref_clk,
    input  wire logic                      nrst,
    // Strap pins
    input  wire logic [scs_pkg::STRAP_N-1:0] strap_in,
    input  wire logic                      core_rst_n,
    output logic [scs_pkg::STRAP_N-1:0]    strap_out,
    output logic [scs_pkg::STRAP_N-1:0]    strap_oe_n,
    output logic                           strap_pulldown_en,
    // Same-domain controls
    input  wire logic                      idle_mode,
    input  wire logic                      addr_cfg_en,
    // Decoded configuration
    output logic [1:0]                     env_code,
    output logic                           float_all,
    output logic                           shared_bios_en,
    output logic [15:0]                    cfg_index_addr,
    output logic [15:0]                    cfg_data_addr,
    output logic                           config_valid,
    // Register port
    input  wire logic [scs_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]                reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic [7:0]                     reg_rdata
);
    import scs_pkg::*;

    localparam int PIN_W = STRAP_N + 1;

    scs_strap_if #(.W(PIN_W)) pins ();

    scs_sync #(.W(PIN_W)) u_sync (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .pins    (pins)
    );

    assign pins.raw = {core_rst_n, strap_in};

    // -------------------------------------------------------------------
    // Capture sequence
    // -------------------------------------------------------------------
    scs_state_e   state;
    scs_state_e   next_state;
    logic [1:0]   fill_cnt;
    logic [1:0]   next_fill_cnt;
    logic [7:0]   status;
    logic [7:0]   next_status;
    logic         next_pulldown_en;
    logic         next_config_valid;
    logic [STRAP_N-1:0] straps_s;
    logic         core_rst_s;

    assign straps_s   = pins.synced[STRAP_N-1:0];
    assign core_rst_s = pins.synced[STRAP_N];

    always_comb begin
        next_state        = state;
        next_fill_cnt     = fill_cnt;
        next_status       = status;
        next_pulldown_en  = strap_pulldown_en;
        next_config_valid = config_valid;
        case (state)
            SCS_SAMPLE: begin
                next_fill_cnt = fill_cnt + 2'h1;
                if (fill_cnt == SYNC_FILL) begin
                    next_state = SCS_CAPTURE;
                end
            end
            SCS_CAPTURE: begin
                next_status       = {2'h0, straps_s};
                next_pulldown_en  = 1'b0;
                next_config_valid = 1'b1;
                next_state        = SCS_RUN;
            end
            SCS_RUN: begin
                next_state = SCS_RUN;
            end
            default: begin
                next_state = SCS_SAMPLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state             <= SCS_SAMPLE;
            fill_cnt          <= 2'h0;
            status            <= STATUS_RESET;
            strap_pulldown_en <= 1'b1;
            config_valid      <= 1'b0;
        end else begin
            state             <= next_state;
            fill_cnt          <= next_fill_cnt;
            status            <= next_status;
            strap_pulldown_en <= next_pulldown_en;
            config_valid      <= next_config_valid;
        end
    end

    // -------------------------------------------------------------------
    // Decode and pin control
    // -------------------------------------------------------------------
    logic [1:0]         next_env_code;
    logic               next_float_all;
    logic               next_shared_bios_en;
    logic [15:0]        next_index_addr;
    logic [STRAP_N-1:0] next_strap_oe_n;
    logic [7:0]         next_rdata;

    always_comb begin
        next_env_code       = {status[BIT_ENV_SELECT_1], status[BIT_ENV_SELECT_0]};
        next_float_all      = status[BIT_FLOAT] &&
                              (next_env_code == INTERNAL_ROM_ENV ||
                               next_env_code == ONBOARD_DEBUG_ENV);
        next_shared_bios_en = status[BIT_SHBIOS];
        case ({status[BIT_BASE1], status[BIT_BASE0]})
            2'h0:    next_index_addr = CFG_BASE_2E;
            2'h1:    next_index_addr = CFG_BASE_4E;
            default: next_index_addr = CORE_BASE;
        endcase
        next_strap_oe_n = '1;
        if (config_valid && !next_float_all) begin
            if (idle_mode && IDLE_DRIVE) begin
                next_strap_oe_n = '0;
            end
            if (addr_cfg_en && !core_rst_s) begin
                next_strap_oe_n[BIT_BASE0] = 1'b0;
                next_strap_oe_n[BIT_BASE1] = 1'b0;
            end
        end
        next_rdata = 8'h00;
        if (reg_rd && reg_addr == STATUS_ADDR) begin
            next_rdata = status;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            env_code       <= INTERNAL_ROM_ENV;
            float_all      <= 1'b0;
            shared_bios_en <= 1'b0;
            cfg_index_addr <= ADDR_RESET;
            cfg_data_addr  <= ADDR_RESET;
            strap_out      <= '0;
            strap_oe_n     <= '1;
            reg_rdata      <= 8'h00;
        end else begin
            env_code       <= next_env_code;
            float_all      <= next_float_all;
            shared_bios_en <= next_shared_bios_en;
            cfg_index_addr <= next_index_addr;
            cfg_data_addr  <= next_index_addr + 16'h0001;
            strap_out      <= status[STRAP_N-1:0];
            strap_oe_n     <= next_strap_oe_n;
            reg_rdata      <= next_rdata;
        end
    end

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence s_status_read;
        reg_rd && reg_addr == STATUS_ADDR;
    endsequence
    sequence s_settled;
        state == SCS_RUN ##1 state == SCS_RUN;
    endsequence

    chk_pulldown_window: assert property (state == SCS_RUN |-> !strap_pulldown_en)
        else $error("pull-downs active after capture");
    chk_capture_hold: assert property (state == SCS_RUN |=> $stable(status))
        else $error("captured straps changed");
    chk_capture_value: assert property (state == SCS_CAPTURE |=> status[STRAP_N-1:0] == $past(straps_s))
        else $error("capture missed strap levels");
    chk_env_decode: assert property (s_settled |-> env_code == {status[BIT_ENV_SELECT_1], status[BIT_ENV_SELECT_0]})
        else $error("environment code wrong");
    chk_float_gate: assert property (s_settled |-> float_all == (status[BIT_FLOAT] && !status[BIT_ENV_SELECT_0]))
        else $error("float-all decode wrong");
    chk_shared_bios: assert property (s_settled |-> shared_bios_en == status[BIT_SHBIOS])
        else $error("shared BIOS enable wrong");
    chk_base_default: assert property (s_settled ##0 status[BIT_BASE1:BIT_BASE0] == 2'h0
        |-> cfg_index_addr == 16'h002e && cfg_data_addr == 16'h002f)
        else $error("base address not 2E");
    chk_base_alt: assert property (s_settled ##0 status[BIT_BASE1:BIT_BASE0] == 2'h1
        |-> cfg_index_addr == 16'h004e && cfg_data_addr == 16'h004f)
        else $error("base address not 4E");
    chk_read_latency: assert property (s_status_read |=> reg_rdata == $past(status))
        else $error("status read data wrong");
    chk_write_ignored: assert property (reg_wr && state == SCS_RUN |=> ##1 status == $past(status, 2))
        else $error("write altered status");
    chk_idle_drive: assert property (IDLE_DRIVE && config_valid && idle_mode && !float_all && !next_float_all
        |=> strap_oe_n == '0)
        else $error("idle pins not driven");
    chk_float_quiet: assert property (float_all |-> strap_oe_n == '1)
        else $error("pins driven while floating");
    chk_addr_drive: assert property (config_valid && !next_float_all && addr_cfg_en && !core_rst_s
        |=> strap_oe_n[BIT_BASE1:BIT_BASE0] == 2'h0)
        else $error("base pins not driven");
endmodule

// ===== inc/scs_pkg.sv
// Constants and types for the strap configuration sampler
package scs_pkg;
    // -------------------------------------------------------------------
    // Register map
    // -------------------------------------------------------------------
    localparam int          ADDR_W          = 24;
    localparam logic [23:0] STATUS_ADDR     = 24'hff12;
    localparam logic [7:0]  STATUS_RESET    = 8'h00;
    // Status byte layout
    localparam int          BIT_ENV_SELECT_0        = 0;
    localparam int          BIT_ENV_SELECT_1        = 1;
    localparam int          BIT_SHBIOS      = 2;
    localparam int          BIT_BASE0       = 3;
    localparam int          BIT_BASE1       = 4;
    localparam int          BIT_FLOAT       = 5;
    localparam int          STRAP_N         = 6;
    // -------------------------------------------------------------------
    // Environment codes {env_select_1, env_select_0}
    // -------------------------------------------------------------------
    localparam logic [1:0]  INTERNAL_ROM_ENV  = 2'h0;
    localparam logic [1:0]  DEVELOPMENT_ENV   = 2'h1;
    localparam logic [1:0]  ONBOARD_DEBUG_ENV = 2'h2;
    localparam logic [1:0]  PROGRAMMING_ENV   = 2'h3;
    // -------------------------------------------------------------------
    // Configuration base addresses and timing
    // -------------------------------------------------------------------
    localparam logic [15:0] CFG_BASE_2E     = 16'h002e;
    localparam logic [15:0] CFG_BASE_4E     = 16'h004e;
    localparam logic [15:0] CFG_BASE_CORE   = 16'h0000;
    localparam int          SYNC_STAGES     = 2;
    localparam logic [1:0]  SYNC_FILL       = 2'h2;
    localparam logic [15:0] ADDR_RESET      = 16'h0000;

    typedef enum logic [2:0] {
        SCS_SAMPLE  = 3'b001,
        SCS_CAPTURE = 3'b010,
        SCS_RUN     = 3'b100
    } scs_state_e;
endpackage

// ===== inc/scs_strap_if.sv
// Raw and synchronised strap levels between sampler and synchroniser
`timescale 1ns/10ps
interface scs_strap_if #(parameter int W = 7);
    logic [W-1:0] raw;
    logic [W-1:0] synced;
    modport sync_side (input raw, output synced);
    modport user_side (output raw, input synced);
endinterface

// ===== verilog/scs_sync.sv
// Two-stage synchroniser for pin-level inputs
`timescale 1ns/10ps
module scs_sync #(
    parameter int W = 7
) (
    input  wire logic          ref_clk,
    input  wire logic          nrst,
    scs_strap_if.sync_side     pins
);
    import scs_pkg::*;

    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] next_stage1;
    logic [W-1:0] next_stage2;

    initial begin
        if (W < 1) $error("scs_sync: width must be at least 1");
    end

    always_comb begin
        next_stage1 = pins.raw;
        next_stage2 = stage1;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            stage1 <= '0;
            stage2 <= '0;
        end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
        end
    end

    assign pins.synced = stage2;
endmodule

// ===== tb/scs_board_model.sv
// Board strap resistors and drivers seen at the strap pins
`timescale 1ns/10ps
module scs_board_model (
    input  wire logic       ref_clk,
    input  wire logic [5:0] pull_up,
    input  wire logic [5:0] strap_out,
    input  wire logic [5:0] strap_oe_n,
    input  wire logic       strap_pulldown_en,
    output logic      [5:0] strap_in
);
    logic [5:0] last;

    always_ff @(posedge ref_clk) begin
        last <= strap_in;
    end

    // Device drive wins, then external pull-up, then internal pull-down
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (!strap_oe_n[i]) begin
                strap_in[i] = strap_out[i];
            end else if (pull_up[i]) begin
                strap_in[i] = 1'b1;
            end else if (strap_pulldown_en) begin
                strap_in[i] = 1'b0;
            end else begin
                strap_in[i] = ~last[i];
            end
        end
    end
endmodule

// ===== tb/scs_top_tb_top.sv
// Self-checking bench for the strap sampler
`timescale 1ns/10ps
module scs_top_tb_top;
    import scs_pkg::*;
    logic ref_clk = 1'b0, nrst = 1'b0, core_rst_n = 1'b1, idle_mode = 1'b0, addr_cfg_en = 1'b0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, strap_pulldown_en, float_all, shared_bios_en, config_valid;
    logic [23:0] reg_addr = 24'h000000;
    logic [7:0]  reg_wdata = 8'h00, reg_rdata;
    logic [5:0]  pull_up = 6'h00, strap_in, strap_out, strap_oe_n;
    logic [1:0]  env_code;
    logic [15:0] cfg_index_addr, cfg_data_addr;
    int          mismatches = 0, samples_checked = 0;

    always #20 ref_clk = ~ref_clk;

    scs_top scs_top_inst (.ref_clk(ref_clk), .nrst(nrst), .strap_in(strap_in), .core_rst_n(core_rst_n),
        .strap_out(strap_out), .strap_oe_n(strap_oe_n), .strap_pulldown_en(strap_pulldown_en),
        .idle_mode(idle_mode), .addr_cfg_en(addr_cfg_en), .env_code(env_code), .float_all(float_all),
        .shared_bios_en(shared_bios_en), .cfg_index_addr(cfg_index_addr), .cfg_data_addr(cfg_data_addr),
        .config_valid(config_valid), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    scs_board_model scs_board_model_inst (.ref_clk(ref_clk), .pull_up(pull_up), .strap_out(strap_out),
        .strap_oe_n(strap_oe_n), .strap_pulldown_en(strap_pulldown_en), .strap_in(strap_in));

    // -------------------------------------------------------------------
    // Shared tasks
    // -------------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_read(input logic [23:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic reg_write(input logic [23:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic complete_run;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // -------------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------------
    task automatic test_power_up(input logic [5:0] p);
        logic [7:0]  d;
        logic [15:0] idx;
        idx = p[4] ? 16'h0000 : (p[3] ? 16'h004e : 16'h002e);
        @(posedge ref_clk);
        nrst    <= 1'b0;
        pull_up <= p;
        repeat (12) @(posedge ref_clk);
        check("pulldown_in_reset", 16'h1, {15'h0, strap_pulldown_en});
        check("valid_in_reset", 16'h0, {15'h0, config_valid});
        nrst <= 1'b1;
        for (int i = 0; i < 20 && config_valid !== 1'b1; i++) @(posedge ref_clk);
        repeat (2) @(posedge ref_clk);
        #1 check("pulldown_after", 16'h0, {15'h0, strap_pulldown_en});
        check("config_valid", 16'h1, {15'h0, config_valid});
        check("env_code", {14'h0, p[1:0]}, {14'h0, env_code});
        check("float_all", {15'h0, p[5] & ~p[0]}, {15'h0, float_all});
        check("shared_bios", {15'h0, p[2]}, {15'h0, shared_bios_en});
        check("cfg_index", idx, cfg_index_addr);
        check("cfg_data", idx + 16'h1, cfg_data_addr);
        reg_read(24'hff12, d);
        check("status", {10'h0, p}, {8'h0, d});
        $display("test power_up %h done", p);
    endtask

    task automatic test_hold_and_writes(input logic [5:0] p);
        logic [7:0] d;
        @(posedge ref_clk);
        pull_up <= ~p;
        reg_write(24'hff12, 8'hff);
        reg_read(24'hff12, d);
        check("status_held", {10'h0, p}, {8'h0, d});
        reg_read(24'hff13, d);
        check("unmapped", 16'h0, {8'h0, d});
        check("env_held", {14'h0, p[1:0]}, {14'h0, env_code});
        pull_up <= p;
        $display("test hold_and_writes done");
    endtask

    task automatic test_idle(input logic [5:0] p);
        @(posedge ref_clk);
        idle_mode <= 1'b1;
        repeat (4) @(posedge ref_clk);
        #1 check("idle_oe_n", (p[5] & ~p[0]) ? 16'h3f : 16'h0, {10'h0, strap_oe_n});
        if (!(p[5] & ~p[0])) check("idle_out", {10'h0, p}, {10'h0, strap_out});
        @(posedge ref_clk);
        idle_mode <= 1'b0;
        $display("test idle done");
    endtask

    task automatic test_addr_cfg(input logic [5:0] p);
        @(posedge ref_clk);
        addr_cfg_en <= 1'b1;
        core_rst_n  <= 1'b0;
        repeat (6) @(posedge ref_clk);
        #1 check("base_oe_n", 16'h0, {14'h0, strap_oe_n[4:3]});
        check("base_out", {14'h0, p[4:3]}, {14'h0, strap_out[4:3]});
        @(posedge ref_clk);
        addr_cfg_en <= 1'b0;
        core_rst_n  <= 1'b1;
        repeat (6) @(posedge ref_clk);
        $display("test addr_cfg done");
    endtask

    // Board straps; never both environment straps high, float only in ROM/debug
    logic [5:0] pats [7] = '{6'h00, 6'h0a, 6'h05, 6'h19, 6'h20, 6'h22, 6'h16};

    initial begin
        #(40 * 5000);
        mismatches++;
        complete_run();
    end

    initial begin
        foreach (pats[i]) test_power_up(pats[i]);
        test_hold_and_writes(6'h16);
        test_idle(6'h16);
        test_power_up(6'h0a);
        test_idle(6'h0a);
        test_addr_cfg(6'h0a);
        test_power_up(6'h20);
        test_idle(6'h20);
        complete_run();
    end
endmodule
